// [pkg/sdas_regs.svh]
// Register indices, field positions, reset values for the SYSREF
// autophase and skew block. Assumes inclusion by bare name.
// What this block does
// - Autophase set: realign divider on captured SYSREF
// - Autophase clear: SYSREF leaves divider phase alone
// - Ignore SYSREF within negative window before edge
// - Negative window applies only while autophase set
// - Skew codes: 0, half, one, one-and-half clocks
// - Record phase; offset is captured plus manual
// - Ignore SYSREF within positive window after edge
`ifndef SDAS_REGS_SVH
`define SDAS_REGS_SVH
// ==========================================
// Register indices (byte address is index times four)
`define SDAS_IDX_DIVCTL 16'h0108
`define SDAS_IDX_MANPH 16'h0109
`define SDAS_IDX_ALIGN 16'h010A
`define SDAS_IDX_OFSST 16'h010B
`define SDAS_IDX_SRMODE 16'h0120
`define SDAS_IDX_CAPST 16'h0129
// ==========================================
// Field positions in the alignment control register
`define SDAS_AUTO_BIT 7
`define SDAS_NEG_HI 3
`define SDAS_NEG_LO 2
`define SDAS_POS_HI 1
`define SDAS_POS_LO 0
// SYSREF mode field
`define SDAS_MODE_HI 2
`define SDAS_MODE_LO 1
// ==========================================
// Reset values
`define SDAS_RST_8 8'h00
`define SDAS_RST_32 32'h0000_0000
`endif

// [pkg/sdas_pkg.sv]
// Types shared by the SYSREF autophase block.
// Assumes the register header is included alongside.
`default_nettype none
package sdas_pkg;
	// ==========================================
	// APB request from the master
	typedef struct packed
	{
		logic psel;
		logic penable;
		logic pwrite;
		logic [15:0] paddr;
		logic [31:0] pwdata;
	} sdas_apb_req_t;
	// ==========================================
	// Fate of a captured SYSREF edge
	typedef enum logic [2:0]
	{
		SDAS_DROP = 3'b001,
		SDAS_SKEW = 3'b010,
		SDAS_ALIGN = 3'b100
	} sdas_fate_t;
endpackage
`default_nettype wire

// [rtl/sdas_top.sv]
// SYSREF driven divider autophase with negative/positive skew windows.
// Assumes capture logic on sys_clk delivers a one-cycle SYSREF pulse
// with its signed distance from the device clock edge in half cycles.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "sdas_regs.svh"
module sdas_top
	import sdas_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire sdas_apb_req_t apbReq,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sysrefCap,
	input wire logic signed [2:0] sysrefDist,
	output logic [3:0] divPhase,
	output logic [3:0] effPhase,
	output logic realignPulse,
	output logic ignorePulse
);
	// ==========================================
	// Helper functions
	// Byte address of a register index
	function automatic logic [15:0] byteAddr(input logic [15:0] idx);
		byteAddr = {idx[13:0], 2'b00};
	endfunction

	// Half-cycle wrap mask for a divider select
	function automatic logic [3:0] phMask(input logic [2:0] sel);
		case (sel[1:0])
			2'b01: phMask = 4'h3;
			2'b11: phMask = 4'h7;
			default: phMask = 4'h1;
		endcase
	endfunction

	// Distance lies inside a skew window of given code
	function automatic logic inWin(input logic [2:0] mag,
		input logic [1:0] code);
		inWin = (mag != 3'h0) && (mag <= {1'b0, code});
	endfunction

	// ==========================================
	// Registers
	logic [2:0] divSel_r; // Input clock divide select
	logic [3:0] manPh_r; // Manual phase offset
	logic autoEn_r; // Autophase enable
	logic [1:0] negSkew_r; // Negative window code
	logic [1:0] posSkew_r; // Positive window code
	logic [1:0] srMode_r; // SYSREF mode, zero means off
	logic [3:0] capPh_r; // Phase at last accepted SYSREF
	logic [3:0] phaseCnt_r; // Divider phase in half cycles
	logic [3:0] effPh_r; // Effective offset used at realign
	logic realign_r; // Realign happened last cycle
	logic ignore_r; // Edge dropped by a skew window
	logic [31:0] prdata_r; // Read data
	logic pready_r; // Access phase answer
	logic pslverr_r; // Unmapped address answer

	// ==========================================
	// SYSREF decision
	logic modeOn; // SYSREF handling enabled
	logic isNeg; // Edge before clock edge
	logic [2:0] mag; // Distance magnitude
	logic negHit; // Inside negative window
	logic posHit; // Inside positive window
	sdas_fate_t fate; // Outcome for this cycle
	logic [3:0] sumPh; // Captured plus manual

	assign modeOn = (srMode_r != 2'b00);
	assign isNeg = sysrefDist[2];
	assign mag = isNeg ? 3'(-sysrefDist) : 3'(sysrefDist);
	// Window only meaningful while autophase runs
	assign negHit = autoEn_r && isNeg && inWin(mag, negSkew_r);
	assign posHit = autoEn_r && !isNeg && inWin(mag, posSkew_r);
	assign sumPh = 4'(phaseCnt_r + manPh_r);

	// Pick what happens to a captured edge
	always_comb
	begin
		fate = SDAS_DROP;
		// Mode off: software is mid-change of skew fields
		if (!sysrefCap || !modeOn)
		begin
			fate = SDAS_DROP;
		end
		else if (!autoEn_r)
		begin
			fate = SDAS_DROP;
		end
		else if (negHit || posHit)
		begin
			fate = SDAS_SKEW;
		end
		else
		begin
			fate = SDAS_ALIGN;
		end
	end

	// ==========================================
	// Divider phase counter, two half cycles per clock
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			phaseCnt_r <= 4'h0;
		end
		else if (fate == SDAS_ALIGN)
		begin
			// Jump to captured plus manual offset
			phaseCnt_r <= sumPh & phMask(divSel_r);
		end
		else
		begin
			phaseCnt_r <= 4'(phaseCnt_r + 4'h2) & phMask(divSel_r);
		end
	end

	// Capture status and effective offset
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			capPh_r <= 4'h0;
			effPh_r <= 4'h0;
		end
		else if (fate == SDAS_ALIGN)
		begin
			capPh_r <= phaseCnt_r;
			effPh_r <= sumPh;
		end
	end

	// Event pulses
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			realign_r <= 1'b0;
			ignore_r <= 1'b0;
		end
		else
		begin
			realign_r <= (fate == SDAS_ALIGN);
			ignore_r <= (fate == SDAS_SKEW);
		end
	end

	// ==========================================
	// APB slave, one wait state
	logic acc; // Access phase, not yet answered
	logic hitDiv, hitMan, hitAli, hitOfs, hitMod, hitCap;
	logic mapped;

	assign acc = apbReq.psel && apbReq.penable && !pready_r;
	assign hitDiv = apbReq.paddr == byteAddr(`SDAS_IDX_DIVCTL);
	assign hitMan = apbReq.paddr == byteAddr(`SDAS_IDX_MANPH);
	assign hitAli = apbReq.paddr == byteAddr(`SDAS_IDX_ALIGN);
	assign hitOfs = apbReq.paddr == byteAddr(`SDAS_IDX_OFSST);
	assign hitMod = apbReq.paddr == byteAddr(`SDAS_IDX_SRMODE);
	assign hitCap = apbReq.paddr == byteAddr(`SDAS_IDX_CAPST);
	assign mapped = hitDiv || hitMan || hitAli || hitOfs || hitMod || hitCap;

	// Handshake; pready drops after one cycle so penable can fall
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			pready_r <= acc;
			pslverr_r <= acc && !mapped;
		end
	end

	// Writable fields; writes land at the answering edge
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			divSel_r <= 3'h0;
			manPh_r <= 4'h0;
			autoEn_r <= 1'b0;
			negSkew_r <= 2'h0;
			posSkew_r <= 2'h0;
			srMode_r <= 2'h0;
		end
		else if (apbReq.psel && apbReq.penable && pready_r && apbReq.pwrite)
		begin
			// Decode on address; status registers ignore writes
			if (hitDiv)
			begin
				divSel_r <= apbReq.pwdata[2:0];
			end
			if (hitMan)
			begin
				manPh_r <= apbReq.pwdata[3:0];
			end
			if (hitAli)
			begin
				autoEn_r <= apbReq.pwdata[`SDAS_AUTO_BIT];
				negSkew_r <= apbReq.pwdata[`SDAS_NEG_HI:`SDAS_NEG_LO];
				posSkew_r <= apbReq.pwdata[`SDAS_POS_HI:`SDAS_POS_LO];
			end
			if (hitMod)
			begin
				srMode_r <= apbReq.pwdata[`SDAS_MODE_HI:`SDAS_MODE_LO];
			end
		end
	end

	// Read mux; reserved bits and unmapped read as zero
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			prdata_r <= `SDAS_RST_32;
		end
		else if (acc && !apbReq.pwrite)
		begin
			prdata_r <= `SDAS_RST_32;
			if (hitDiv)
			begin
				prdata_r <= {29'h0, divSel_r};
			end
			if (hitMan)
			begin
				prdata_r <= {28'h0, manPh_r};
			end
			if (hitAli)
			begin
				prdata_r <= {24'h0, autoEn_r, 3'h0, negSkew_r, posSkew_r};
			end
			if (hitOfs)
			begin
				prdata_r <= {28'h0, effPh_r};
			end
			if (hitMod)
			begin
				prdata_r <= {29'h0, srMode_r, 1'b0};
			end
			if (hitCap)
			begin
				prdata_r <= {28'h0, capPh_r};
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign divPhase = phaseCnt_r;
	assign effPhase = effPh_r;
	assign realignPulse = realign_r;
	assign ignorePulse = ignore_r;

	// ==========================================
	// Assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	AST_REALIGN: assert property (sysrefCap && modeOn && autoEn_r
		&& !negHit && !posHit |=> realign_r
		&& capPh_r == $past(phaseCnt_r))
		else $error("accepted SYSREF did not realign");
	AST_NO_AUTO: assert property (!autoEn_r |=> !realign_r
		&& $stable(capPh_r))
		else $error("SYSREF changed phase with autophase off");
	AST_NEG_IGN: assert property (sysrefCap && modeOn && autoEn_r
		&& isNeg && mag != 3'h0 && mag <= {1'b0, negSkew_r}
		|=> ignore_r && !realign_r)
		else $error("edge in negative window not ignored");
	AST_NEG_AUTO: assert property (!autoEn_r |=> !ignore_r)
		else $error("skew window used with autophase off");
	AST_NEG_CODE: assert property (sysrefCap && modeOn && autoEn_r
		&& isNeg && mag == {1'b0, negSkew_r} + 3'h1 && !posHit
		|=> realign_r)
		else $error("negative window wider than its code");
	AST_EFF_SUM: assert property (realign_r |->
		effPh_r == 4'(capPh_r + $past(manPh_r)))
		else $error("effective offset not captured plus manual");
	AST_POS_IGN: assert property (sysrefCap && modeOn && autoEn_r
		&& !isNeg && mag != 3'h0 && mag <= {1'b0, posSkew_r}
		|=> ignore_r && !realign_r)
		else $error("edge in positive window not ignored");
	AST_MODE_OFF: assert property (!modeOn |=> !realign_r
		&& !ignore_r)
		else $error("SYSREF acted while mode off");
	AST_PHASE_LOAD: assert property (realign_r |->
		phaseCnt_r == (effPh_r & phMask($past(divSel_r))))
		else $error("divider phase not loaded on realign");
	AST_APB_ANS: assert property (acc |=> pready_r ##1 !pready_r)
		else $error("APB answer not one cycle");

	COV_ALIGN: cover property (realign_r);
	COV_SKEW: cover property (ignore_r ##[1:20] realign_r);
	COV_RD: cover property (pready_r && !apbReq.pwrite && hitCap);
endmodule
`default_nettype wire

// [verification/sdas_sysref_gen.sv]
// Model of the clock generator side: delivers captured SYSREF edges.
// Assumes the bench requests an edge with fire, one cycle at a time.
`timescale 1ns/1ps
`default_nettype none
module sdas_sysref_gen
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic fire,
	input wire logic signed [2:0] fireDist,
	output logic sysrefCap,
	output logic signed [2:0] sysrefDist
);
	// ==========================================
	// Edge pulse; distance toggles when idle so stale values never match
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			sysrefCap <= 1'b0;
			sysrefDist <= 3'h5;
		end
		else if (fire)
		begin
			sysrefCap <= 1'b1;
			sysrefDist <= fireDist;
		end
		else
		begin
			sysrefCap <= 1'b0;
			sysrefDist <= ~sysrefDist;
		end
	end
endmodule
`default_nettype wire

// [verification/sdas_top_tb.sv]
// Self-checking bench: APB register access and SYSREF window checks.
// Assumes the design answers APB with one wait state, pulses a cycle late.
`timescale 1ns/1ps
`default_nettype none
module sdas_top_tb
	import sdas_pkg::*;
;
	logic sys_clk, rst, fire, sysrefCap, realignPulse, ignorePulse;
	logic pready, pslverr;
	logic signed [2:0] fireDist, sysrefDist;
	logic [3:0] divPhase, effPhase, ph;
	logic [3:0] man; // Manual phase offset last written
	logic [31:0] prdata, rd;
	logic err;
	sdas_apb_req_t req;
	int nErrors, numChecks;
	sdas_top DUT (.sys_clk(sys_clk), .rst(rst), .apbReq(req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sysrefCap(sysrefCap), .sysrefDist(sysrefDist),
		.divPhase(divPhase), .effPhase(effPhase),
		.realignPulse(realignPulse), .ignorePulse(ignorePulse));
	sdas_sysref_gen gen (.sys_clk(sys_clk), .rst(rst), .fire(fire),
		.fireDist(fireDist), .sysrefCap(sysrefCap),
		.sysrefDist(sysrefDist));
	// ==========================================
	// Clock at 250 MHz
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// Verdict in one place
	task automatic endOfTest();
		$display("checks %0d mismatches %0d", numChecks, nErrors);
		if (nErrors == 0 && numChecks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		numChecks++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask
	// APB cycle; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [15:0] a,
		input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge sys_clk);
		req <= '{1'b1, 1'b0, wr, a, wd};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		req <= '0;
		if (n >= 20)
		begin
			nErrors++;
			endOfTest();
		end
	endtask
	// Skew change only with SYSREF mode off, then mode back on
	task automatic cfg(input logic [7:0] ctl);
		apb(1'b1, 16'h0480, 32'h0000_0000);
		apb(1'b1, 16'h0428, {24'h0, ctl});
		apb(1'b1, 16'h0428 ^ 16'h0000, 32'h0000_0000 | ctl);
		apb(1'b0, 16'h0428, 32'h0000_0000);
		chk("ctl", rd, {24'h0, ctl});
		apb(1'b1, 16'h0480, 32'h0000_0002);
	endtask
	// One captured edge; ph is the divider phase the design sees
	task automatic sref(input int d, input logic r, input logic i);
		logic [3:0] want;
		@(posedge sys_clk);
		fire <= 1'b1;
		fireDist <= 3'(d);
		@(posedge sys_clk);
		fire <= 1'b0;
		#1 ph = divPhase;
		@(posedge sys_clk);
		#1 chk("realign", {31'h0, realignPulse}, {31'h0, r});
		chk("ignore", {31'h0, ignorePulse}, {31'h0, i});
		// Divide by four: period of eight half cycles, so wrap mask 7
		want = 4'(ph + (r ? man : 4'h2)) & 4'h7;
		if (r)
			chk("aligned phase", {28'h0, divPhase}, {28'h0, want});
		else
			chk("free phase", {28'h0, divPhase}, {28'h0, want});
	endtask
	// ==========================================
	// Main sequence
	initial
	begin
		rst = 1'b1;
		req = '0;
		fire = 1'b0;
		fireDist = 3'h0;
		man = 4'h0;
		nErrors = 0;
		numChecks = 0;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		apb(1'b0, 16'h0428, 32'h0000_0000);
		chk("ctl reset", rd, 32'h0000_0000);
		apb(1'b0, 16'h0500, 32'h0000_0000);
		chk("unmapped", {31'h0, err}, 32'h0000_0001);
		$display("test reset done");
		apb(1'b1, 16'h0420, 32'h0000_0003);
		cfg(8'h0C);
		sref(-1, 1'b0, 1'b0);
		sref(0, 1'b0, 1'b0);
		$display("test autophase off done");
		for (int c = 0; c < 4; c++)
		begin
			cfg(8'h80 | 8'(c << 2));
			if (c > 0)
				sref(-c, 1'b0, 1'b1);
			sref(-c - 1, 1'b1, 1'b0);
		end
		$display("test negative window done");
		cfg(8'h82);
		sref(2, 1'b0, 1'b1);
		sref(3, 1'b1, 1'b0);
		$display("test positive window done");
		apb(1'b1, 16'h0424, 32'h0000_0003);
		man = 4'h3;
		cfg(8'h80);
		sref(0, 1'b1, 1'b0);
		chk("effPhase", {28'h0, effPhase}, {28'h0, ph + 4'h3});
		apb(1'b0, 16'h04A4, 32'h0000_0000);
		chk("captured", rd, {28'h0, ph});
		apb(1'b0, 16'h042C, 32'h0000_0000);
		chk("offset", rd, {28'h0, ph + 4'h3});
		$display("test phase done");
		endOfTest();
	end
endmodule
`default_nettype wire
